//--- rtl/dowc_pkg.sv
// Package: register map, field positions and state types of the DAC write control
package dowc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [7:0] OFS_STATUS_PRIMARY = 8'h03; // Read side
    localparam logic [7:0] OFS_INT_ACK_TWO = 8'h03;    // Write side
    localparam logic [7:0] OFS_CMD_SECOND = 8'h05;
    localparam logic [7:0] OFS_SHARED_STATUS_ONE = 8'h1b;
    localparam logic [7:0] OFS_SHARED_STATUS_TWO = 8'h1d;
    localparam logic [7:0] OFS_MODE_FIRST = 8'h26;
    localparam logic [7:0] OFS_MODE_SECOND = 8'h27;
    localparam logic [7:0] OFS_CLOCK_FOUT = 8'h38;
    localparam logic [7:0] OFS_START_SELECT = 8'h42;
    localparam logic [7:0] OFS_TRIG_SELECT = 8'h43;
    localparam logic [7:0] OFS_MODE_THIRD = 8'h46;
    localparam logic [7:0] OFS_SHARED_RESET = 8'h48;
    localparam logic [7:0] OFS_PERSONALITY = 8'h4e;
    localparam logic [7:0] OFS_OUTPUT_CTRL = 8'h56;

    // Field positions
    localparam int BIT_MUTE_B = 3;          // Command second
    localparam int BIT_PRELOAD = 2;         // Mode third
    localparam int BIT_SOFT_PAUSE = 1;      // Mode third
    localparam int BIT_MULTI_CHAN = 5;      // Mode first
    localparam int BIT_TRIG1_MASK = 12;     // Mode second
    localparam int BIT_TRIG1_EDGE = 5;      // Trigger select
    localparam int BIT_FIFO_WR_EN = 10;     // Personality
    localparam int BIT_PULSE_WIDTH = 12;    // Personality
    localparam int BIT_PKG_MODE = 14;       // Personality
    localparam int BIT_SRC_HALF = 4;        // Clock and FOUT
    localparam int BIT_OUT_HALF = 5;        // Clock and FOUT
    localparam int BIT_SECTION_RESET = 1;   // Shared reset
    localparam int BIT_START_TRIGGER_ONE_ACK = 9;      // Interrupt ack two
    localparam int BIT_ERROR_ACK = 14;      // Interrupt ack two
    localparam int BIT_CHAN_LSB = 6;        // Output control, 4 bits
    localparam int BIT_ST_START_TRIGGER_ONE = 8;       // Status primary
    localparam int BIT_ST_OVERRUN = 9;      // Status primary
    localparam int BIT_ST_FIFO_EMPTY = 12;  // Status primary
    localparam int BIT_ST_GATE = 11;        // Shared status one
    localparam int BIT_ST_BUSY = 5;         // Shared status two

    // Reset values and timing counts
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [1:0] PULSE_LONG = 2'h3;   // Out-timebase periods
    localparam logic [1:0] PULSE_SHORT = 2'h2;

    // Write sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_WAIT = 2'b01,
        SEQ_PULSE = 2'b10,
        SEQ_GAP = 2'b11
    } dowc_seq_e;

    // Outputs toward the DACs
    typedef struct packed {
        logic timed_wr;
        logic [1:0] strobe;
        logic [3:0] addr;
    } dowc_dac_s;

    // Whole state of the control block
    typedef struct packed {
        logic [15:0] cmd2;
        logic [15:0] mode1;
        logic [15:0] mode2;
        logic [15:0] mode3;
        logic [15:0] personal;
        logic [15:0] clkreg;
        logic [15:0] trigsel;
        logic [15:0] startsel;
        logic [15:0] outctl;
        dowc_seq_e st;
        logic [3:0] chan;
        logic [3:0] last;
        logic [1:0] wcnt;
        logic is_cpu;
        logic cpu_pend;
        logic [3:0] cpu_chan;
        logic loaded;
        logic overrun;
        logic start_trigger_one_st;
        logic [2:0] trig_sync;
        logic trig_stab;
        logic trig_prev;
        logic [2:0] fifo_sync;
        logic fifo_empty;
        logic tb_tog;
        logic out_en;
        logic src_en;
        logic upd;
        logic start_trigger_one;
        dowc_dac_s dac;
        logic [15:0] rdata;
    } dowc_state_s;

endpackage

//--- rtl/dowc_top.sv
// DAC write control: update gating, DAC write sequencing, overrun and trigger
`timescale 1ns/1ps
`default_nettype none

module dowc_top (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [15:0] reg_rdata_o,
    input wire logic update_i,
    input wire logic bc_uses_b_i,
    input wire logic cpu_dac_write_i,
    input wire logic [3:0] cpu_chan_i,
    input wire logic fifo_empty_i,
    input wire logic start_trigger_one_i,
    output logic update_o,
    output logic timed_dac_write_o,
    output logic [1:0] dac_write_strobe_o,
    output logic [3:0] dac_channel_addr_o,
    output logic dac_write_busy_o,
    output logic overrun_flag_o,
    output logic start_trigger_one_o,
    output logic out_timebase_en_o,
    output logic src_timebase_en_o
);

    logic [1:0] rst_sync;
    logic srst_n;
    dowc_pkg::dowc_state_s r;
    dowc_pkg::dowc_state_s next_r;

    // True when a write strobe hits the given offset
    function automatic logic wr_hit(input logic we, input logic [7:0] a,
                                    input logic [7:0] ofs);
        wr_hit = we && (a == ofs);
    endfunction

    // Strobe lane for a channel under the selected package mode
    function automatic logic [1:0] lane(input logic pkg_mode,
                                        input logic [3:0] ch);
        if (pkg_mode && ch[0]) begin
            lane = 2'h2;
        end else begin
            lane = 2'h1;
        end
    endfunction

    // Reset release through two flops so every flop leaves reset together
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign srst_n = rst_sync[1];

    // Decoded control bits
    logic mute_b, preload_bit, soft_pause, multi_chan, trig1_mask;
    logic trig1_edge, fifo_wr_en, short_pulse, pkg_mode;
    logic out_half, src_half, busy;
    logic [3:0] chan_count;
    assign mute_b = r.cmd2[dowc_pkg::BIT_MUTE_B];
    assign preload_bit = r.mode3[dowc_pkg::BIT_PRELOAD];
    assign soft_pause = r.mode3[dowc_pkg::BIT_SOFT_PAUSE];
    assign multi_chan = r.mode1[dowc_pkg::BIT_MULTI_CHAN];
    assign trig1_mask = r.mode2[dowc_pkg::BIT_TRIG1_MASK];
    assign trig1_edge = r.trigsel[dowc_pkg::BIT_TRIG1_EDGE];
    assign fifo_wr_en = r.personal[dowc_pkg::BIT_FIFO_WR_EN];
    assign short_pulse = r.personal[dowc_pkg::BIT_PULSE_WIDTH];
    assign pkg_mode = r.personal[dowc_pkg::BIT_PKG_MODE];
    assign out_half = r.clkreg[dowc_pkg::BIT_OUT_HALF];
    assign src_half = r.clkreg[dowc_pkg::BIT_SRC_HALF];
    assign chan_count = r.outctl[dowc_pkg::BIT_CHAN_LSB +: 4];
    // CPU writes do not count as a timed sequence
    assign busy = (r.st != dowc_pkg::SEQ_IDLE) && !r.is_cpu;

    // Next-state logic for the whole block
    always_comb begin
        logic sec_reset, err_ack, s1_ack, upd_req, preload_go;
        logic trig_rise, trig_hit;
        logic [15:0] rd;
        sec_reset = 1'b0;
        err_ack = 1'b0;
        s1_ack = 1'b0;
        upd_req = 1'b0;
        preload_go = 1'b0;
        trig_rise = 1'b0;
        trig_hit = 1'b0;
        rd = 16'h0000;
        next_r = r;
        next_r.upd = 1'b0;
        next_r.start_trigger_one = 1'b0;

        // Register writes; start-select and gate fields are stored only
        if (wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_CMD_SECOND)) begin
            next_r.cmd2 = reg_wdata_i;
        end
        if (wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_MODE_FIRST)) begin
            next_r.mode1 = reg_wdata_i;
        end
        if (wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_MODE_SECOND)) begin
            next_r.mode2 = reg_wdata_i;
        end
        // Preload bit holds whatever software wrote
        if (wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_MODE_THIRD)) begin
            next_r.mode3 = reg_wdata_i;
        end
        if (wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_PERSONALITY)) begin
            next_r.personal = reg_wdata_i;
        end
        if (wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_CLOCK_FOUT)) begin
            next_r.clkreg = reg_wdata_i;
        end
        if (wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_TRIG_SELECT)) begin
            next_r.trigsel = reg_wdata_i;
        end
        // Stored for readback of nothing; has no effect on operation
        if (wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_START_SELECT)) begin
            next_r.startsel = reg_wdata_i;
        end
        if (wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_OUTPUT_CTRL)) begin
            next_r.outctl = reg_wdata_i;
        end

        // Strobe bits act for the one write cycle and are never stored
        sec_reset = wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_SHARED_RESET)
                    && reg_wdata_i[dowc_pkg::BIT_SECTION_RESET];
        err_ack = wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_INT_ACK_TWO)
                  && reg_wdata_i[dowc_pkg::BIT_ERROR_ACK];
        s1_ack = wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_INT_ACK_TWO)
                 && reg_wdata_i[dowc_pkg::BIT_START_TRIGGER_ONE_ACK];
        // Falling write of the preload bit launches a preload sequence
        preload_go = wr_hit(reg_we_i, reg_addr_i, dowc_pkg::OFS_MODE_THIRD)
                     && preload_bit
                     && !reg_wdata_i[dowc_pkg::BIT_PRELOAD];

        // Timebases: a divide by two is an enable every other cycle
        next_r.tb_tog = !r.tb_tog;
        next_r.out_en = !out_half || r.tb_tog;
        next_r.src_en = !src_half || r.tb_tog;

        // Pin synchronisers; a change counts once stages two and three agree
        next_r.trig_sync = {r.trig_sync[1:0], start_trigger_one_i};
        if (r.trig_sync[1] == r.trig_sync[2]) begin
            next_r.trig_stab = r.trig_sync[2];
        end
        next_r.fifo_sync = {r.fifo_sync[1:0], fifo_empty_i};
        if (r.fifo_sync[1] == r.fifo_sync[2]) begin
            next_r.fifo_empty = r.fifo_sync[2];
        end

        // Trigger one recognition
        next_r.trig_prev = r.trig_stab;
        trig_rise = r.trig_stab && !r.trig_prev;
        trig_hit = trig1_edge ? trig_rise : r.trig_stab;
        if (!trig1_mask && trig_hit) begin
            next_r.start_trigger_one = 1'b1;
        end
        // Acknowledge first so a trigger in the same cycle still sets
        if (s1_ack) begin
            next_r.start_trigger_one_st = 1'b0;
        end
        if (!trig1_mask && trig_hit) begin
            next_r.start_trigger_one_st = 1'b1;
        end

        // Overrun clears on acknowledge; a new overrun in that cycle wins
        if (err_ack) begin
            next_r.overrun = 1'b0;
        end

        // Updates pass unless paused or muted on load register B
        upd_req = update_i && !soft_pause
                  && !(mute_b && bc_uses_b_i);
        if (upd_req) begin
            next_r.upd = 1'b1;
            // DAC not refreshed since the last update, or still loading
            if (!r.loaded || busy) begin
                next_r.overrun = 1'b1;
            end
            next_r.loaded = 1'b0;
        end

        // Write sequencer, stepping on the out-timebase enable
        unique case (r.st)
            dowc_pkg::SEQ_IDLE: begin
                if (upd_req || preload_go) begin
                    // Multi mode walks 0..count, single mode writes count
                    next_r.chan = multi_chan ? 4'h0 : chan_count;
                    next_r.last = chan_count;
                    next_r.is_cpu = 1'b0;
                    next_r.st = dowc_pkg::SEQ_WAIT;
                end else if (r.cpu_pend) begin
                    next_r.chan = r.cpu_chan;
                    next_r.last = r.cpu_chan;
                    next_r.is_cpu = 1'b1;
                    next_r.cpu_pend = 1'b0;
                    next_r.st = dowc_pkg::SEQ_WAIT;
                end
            end
            dowc_pkg::SEQ_WAIT: begin
                // Timed writes need FIFO enable and data in the FIFO
                if (r.out_en && !soft_pause && (r.is_cpu
                    || (fifo_wr_en && !r.fifo_empty))) begin
                    next_r.st = dowc_pkg::SEQ_PULSE;
                    next_r.wcnt = (short_pulse ? dowc_pkg::PULSE_SHORT
                                   : dowc_pkg::PULSE_LONG) - 2'h1;
                    next_r.dac.timed_wr = !r.is_cpu;
                    next_r.dac.strobe = lane(pkg_mode, r.chan);
                    next_r.dac.addr = r.chan;
                end
            end
            dowc_pkg::SEQ_PULSE: begin
                if (r.out_en) begin
                    if (r.wcnt == 2'h0) begin
                        next_r.dac.timed_wr = 1'b0;
                        next_r.dac.strobe = 2'h0;
                        next_r.st = dowc_pkg::SEQ_GAP;
                    end else begin
                        next_r.wcnt = r.wcnt - 2'h1;
                    end
                end
            end
            dowc_pkg::SEQ_GAP: begin
                // One idle period between writes keeps the strobes apart
                if (r.out_en) begin
                    if (r.is_cpu || r.chan == r.last) begin
                        next_r.st = dowc_pkg::SEQ_IDLE;
                        if (!r.is_cpu && !upd_req) begin
                            next_r.loaded = 1'b1;
                        end
                    end else begin
                        next_r.chan = r.chan + 4'h1;
                        next_r.st = dowc_pkg::SEQ_WAIT;
                    end
                end
            end
        endcase

        // CPU write request waits until the sequencer is free
        if (cpu_dac_write_i) begin
            next_r.cpu_pend = 1'b1;
            next_r.cpu_chan = cpu_chan_i;
        end

        // Section reset restores output registers and clears status
        if (sec_reset) begin
            next_r.cmd2 = dowc_pkg::CFG_RESET;
            next_r.mode1 = dowc_pkg::CFG_RESET;
            next_r.mode2 = dowc_pkg::CFG_RESET;
            next_r.mode3 = dowc_pkg::CFG_RESET;
            next_r.personal = dowc_pkg::CFG_RESET;
            next_r.trigsel = dowc_pkg::CFG_RESET;
            next_r.startsel = dowc_pkg::CFG_RESET;
            next_r.outctl = dowc_pkg::CFG_RESET;
            next_r.overrun = 1'b0;
            next_r.start_trigger_one_st = 1'b0;
            next_r.start_trigger_one = 1'b0;
            next_r.upd = 1'b0;
            next_r.loaded = 1'b0;
            next_r.cpu_pend = 1'b0;
            next_r.is_cpu = 1'b0;
            next_r.st = dowc_pkg::SEQ_IDLE;
            next_r.dac = '0;
        end

        // Read data appear in the cycle after the read strobe
        rd = 16'h0000;
        if (reg_re_i) begin
            unique case (reg_addr_i)
                dowc_pkg::OFS_STATUS_PRIMARY: begin
                    // Unsupported start status reads as zero
                    rd[dowc_pkg::BIT_ST_OVERRUN] = r.overrun;
                    rd[dowc_pkg::BIT_ST_START_TRIGGER_ONE] = r.start_trigger_one_st;
                    rd[dowc_pkg::BIT_ST_FIFO_EMPTY] = r.fifo_empty;
                end
                dowc_pkg::OFS_SHARED_STATUS_ONE: begin
                    rd[dowc_pkg::BIT_ST_GATE] = !soft_pause;
                end
                dowc_pkg::OFS_SHARED_STATUS_TWO: begin
                    rd[dowc_pkg::BIT_ST_BUSY] = busy;
                end
                default: begin
                    rd = 16'h0000;
                end
            endcase
        end
        next_r.rdata = rd;
    end

    // State register; the clock register survives a section reset
    always_ff @(posedge ref_clk_i or negedge srst_n) begin
        if (!srst_n) begin
            r <= '0;
            // Assume an empty FIFO so no write starts before the pin is seen
            r.fifo_sync <= 3'h7;
            r.fifo_empty <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from state
    assign reg_rdata_o = r.rdata;
    assign update_o = r.upd;
    assign timed_dac_write_o = r.dac.timed_wr;
    assign dac_write_strobe_o = r.dac.strobe;
    assign dac_channel_addr_o = r.dac.addr;
    assign dac_write_busy_o = busy;
    assign overrun_flag_o = r.overrun;
    assign start_trigger_one_o = r.start_trigger_one;
    assign out_timebase_en_o = r.out_en;
    assign src_timebase_en_o = r.src_en;

endmodule

`default_nettype wire

//--- sim/dowc_fifo_model.sv
// Far-side model of the board data FIFO that feeds the DACs
`timescale 1ns/1ps
`default_nettype none
module dowc_fifo_model (
    input wire logic ref_clk_i,
    input wire logic timed_dac_write_i,
    input wire logic [3:0] fill_i,
    input wire logic fill_v_i,
    output logic fifo_empty_o
);
    int words = 0;
    logic prev = 1'b0;
    // One word leaves on each timed write unless a fill lands in that cycle; a fill adds words
    always @(posedge ref_clk_i) begin
        if (fill_v_i) begin
            words <= words + int'(fill_i);
        end else if (timed_dac_write_i && !prev && words > 0) begin
            words <= words - 1;
        end
        prev <= timed_dac_write_i;
    end
    // Empty flag changes only on the clock, like a real flag pin
    assign fifo_empty_o = (words == 0);
endmodule
`default_nettype wire

//--- sim/dowc_properties.sv
// Port-level checker of the DAC write control
`timescale 1ns/1ps
`default_nettype none
module dowc_properties (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic update_i,
    input wire logic cpu_dac_write_i,
    input wire logic update_o,
    input wire logic timed_dac_write_o,
    input wire logic [1:0] dac_write_strobe_o,
    input wire logic [3:0] dac_channel_addr_o,
    input wire logic dac_write_busy_o,
    input wire logic overrun_flag_o,
    input wire logic out_timebase_en_o,
    input wire logic src_timebase_en_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Only an error ack or a section reset may drop the overrun flag
    logic ov_clr;
    assign ov_clr = reg_we_i && ((reg_addr_i == 8'h03 && reg_wdata_i[14])
        || (reg_addr_i == 8'h48 && reg_wdata_i[1]));
    sequence s_on;
        $rose(timed_dac_write_o);
    endsequence
    sequence s_width;
        timed_dac_write_o [*2] ##[1:7] !timed_dac_write_o;
    endsequence
    property p_upd_cause;
        update_o |-> $past(update_i);
    endproperty
    a_upd_cause: assert property (p_upd_cause)
        else $error("update pulse without request");
    property p_width;
        s_on |-> s_width;
    endproperty
    a_width: assert property (p_width)
        else $error("timed write pulse width wrong");
    property p_busy;
        timed_dac_write_o |-> dac_write_busy_o;
    endproperty
    a_busy: assert property (p_busy)
        else $error("timed write while not busy");
    property p_strobe;
        timed_dac_write_o |-> $onehot(dac_write_strobe_o);
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("timed write without exactly one strobe");
    property p_addr;
        timed_dac_write_o && $past(timed_dac_write_o)
            |-> $stable(dac_channel_addr_o);
    endproperty
    a_addr: assert property (p_addr)
        else $error("channel address moved inside a pulse");
    property p_cpu;
        cpu_dac_write_i
            |-> ##[1:60] (dac_write_strobe_o != 2'h0 && !timed_dac_write_o);
    endproperty
    a_cpu: assert property (p_cpu)
        else $error("cpu write gave no strobe");
    property p_ov_hold;
        overrun_flag_o && !ov_clr |=> overrun_flag_o;
    endproperty
    a_ov_hold: assert property (p_ov_hold)
        else $error("overrun dropped without ack");
    property p_rd_idle;
        !$past(reg_re_i) |-> reg_rdata_o == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_out_half;
        $fell(out_timebase_en_o) |=> out_timebase_en_o;
    endproperty
    a_out_half: assert property (p_out_half)
        else $error("out timebase slower than half");
    property p_src_half;
        $fell(src_timebase_en_o) |=> src_timebase_en_o;
    endproperty
    a_src_half: assert property (p_src_half)
        else $error("source timebase slower than half");
endmodule
bind dowc_top dowc_properties u_props (.ref_clk_i, .arst_n_i,
    .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
    .update_i, .cpu_dac_write_i, .update_o, .timed_dac_write_o,
    .dac_write_strobe_o, .dac_channel_addr_o, .dac_write_busy_o,
    .overrun_flag_o, .out_timebase_en_o, .src_timebase_en_o);
`default_nettype wire

//--- sim/dowc_top_tb_top.sv
// Self-checking bench of the DAC write control
`timescale 1ns/1ps
`default_nettype none
module dowc_top_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic we = 1'b0, re = 1'b0, upd = 1'b0, bcb = 1'b0;
    logic cpu = 1'b0, trg = 1'b0, fv = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic [3:0] cch = 4'h0, fill = 4'h0, dadr;
    logic [15:0] rdata, v;
    logic uo, tw, busy, ov, st1, oen, sen, fe, ptw = 1'b0;
    logic [1:0] stb, pstb = 2'h0;
    logic [5:0] wq[$];
    int err_total = 0, compares = 0, n_upd = 0, n_tw = 0, n_st = 0;
    int cyc = 0, n0 = 0;
    dowc_top dut (.ref_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata), .update_i(upd), .bc_uses_b_i(bcb),
        .cpu_dac_write_i(cpu), .cpu_chan_i(cch), .fifo_empty_i(fe),
        .start_trigger_one_i(trg), .update_o(uo), .timed_dac_write_o(tw),
        .dac_write_strobe_o(stb), .dac_channel_addr_o(dadr),
        .dac_write_busy_o(busy), .overrun_flag_o(ov), .start_trigger_one_o(st1),
        .out_timebase_en_o(oen), .src_timebase_en_o(sen));
    dowc_fifo_model fifo (.ref_clk_i(clk), .timed_dac_write_i(tw),
        .fill_i(fill), .fill_v_i(fv), .fifo_empty_o(fe));
    initial begin
        forever #5 clk = ~clk;
    end
    // Log each strobe start with its channel, count pulses, cut hangs
    always @(posedge clk) begin
        if (stb !== 2'h0 && pstb === 2'h0) wq.push_back({stb, dadr});
        pstb <= stb;
        ptw <= tw;
        if (tw === 1'b1 && ptw === 1'b0) n_tw++;
        if (uo === 1'b1) n_upd++;
        if (st1 === 1'b1) n_st++;
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Register bus: one-cycle strobes, read data in the next cycle
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk("register read", e, rdata);
    endtask
    task automatic pulse_upd();
        @(posedge clk);
        upd <= 1'b1;
        @(posedge clk);
        upd <= 1'b0;
    endtask
    // Fill waits out the three-flop synchroniser on the empty pin
    task automatic load(input logic [3:0] n);
        @(posedge clk);
        fill <= n;
        fv <= 1'b1;
        @(posedge clk);
        fv <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge clk);
            if (busy === 1'b0) break;
        end
        chk("busy timeout", 16'h0, 16'(i == 300));
    endtask
    task automatic chk_w(input logic [5:0] e);
        logic [5:0] g;
        g = (wq.size() > 0) ? wq.pop_front() : 6'h3f;
        chk("dac write", {10'h0, e}, {10'h0, g});
    endtask
    task automatic t_preload();
        rd(8'h03, 16'h1000);
        rd(8'h7f, 16'h0000);
        rd(8'h1b, 16'h0800);
        wr(8'h4e, 16'h0400);
        wr(8'h56, 16'h0080);
        wr(8'h46, 16'h0004);
        wr(8'h46, 16'h0000);
        repeat (20) @(posedge clk);
        rd(8'h1d, 16'h0020);
        chk("early writes", 16'h0, 16'(wq.size()));
        load(4'h3);
        wait_idle();
        chk_w(6'h12);
        chk("preload updates", 16'h0, 16'(n_upd));
        wr(8'h03, 16'h4000);
        rd(8'h03, 16'h0000);
    endtask
    task automatic t_overrun();
        pulse_upd();
        pulse_upd();
        wait_idle();
        chk_w(6'h12);
        chk("extra writes", 16'h0, 16'(wq.size()));
        rd(8'h03, 16'h0200);
        chk("overrun pin", 16'h0001, 16'(ov));
        repeat (10) @(posedge clk);
        rd(8'h03, 16'h0200);
        wr(8'h03, 16'h4000);
        rd(8'h03, 16'h0000);
    endtask
    task automatic t_multi();
        load(4'h4);
        wr(8'h4e, 16'h4400);
        wr(8'h26, 16'h0020);
        wr(8'h56, 16'h00c0);
        pulse_upd();
        wait_idle();
        for (int i = 0; i < 4; i++) begin
            chk_w({(i % 2) ? 2'b10 : 2'b01, 4'(i)});
        end
    endtask
    task automatic t_mute();
        wr(8'h26, 16'h0000);
        wr(8'h05, 16'h0008);
        bcb <= 1'b1;
        n0 = n_upd;
        pulse_upd();
        repeat (20) @(posedge clk);
        chk("muted updates", 16'(n0), 16'(n_upd));
        chk("muted writes", 16'h0, 16'(wq.size()));
        bcb <= 1'b0;
        pulse_upd();
        wait_idle();
        chk("unmuted updates", 16'(n0 + 1), 16'(n_upd));
        chk_w(6'h23);
    endtask
    task automatic t_pause_reset();
        wr(8'h46, 16'h0002);
        rd(8'h1b, 16'h0000);
        n0 = n_upd;
        pulse_upd();
        repeat (10) @(posedge clk);
        chk("paused updates", 16'(n0), 16'(n_upd));
        wr(8'h46, 16'h0000);
        pulse_upd();
        pulse_upd();
        rd(8'h03, 16'h1200);
        wr(8'h48, 16'h0002);
        rd(8'h03, 16'h1000);
        rd(8'h1d, 16'h0000);
        load(4'h1);
        wr(8'h4e, 16'h0400);
        bcb <= 1'b1;
        n0 = n_upd;
        pulse_upd();
        wait_idle();
        chk("reset mute", 16'(n0 + 1), 16'(n_upd));
        chk_w(6'h10);
        rd(8'h03, 16'h1200);
        wr(8'h03, 16'h4000);
        bcb <= 1'b0;
    endtask
    task automatic t_cpu_trig();
        n0 = n_tw;
        cch <= 4'h5;
        cpu <= 1'b1;
        @(posedge clk);
        cpu <= 1'b0;
        repeat (20) @(posedge clk);
        chk_w(6'h15);
        chk("cpu timed", 16'(n0), 16'(n_tw));
        wr(8'h27, 16'h1000);
        wr(8'h43, 16'h0020);
        n0 = n_st;
        for (int k = 0; k < 2; k++) begin
            trg <= 1'b1;
            repeat (10) @(posedge clk);
            trg <= 1'b0;
            repeat (10) @(posedge clk);
            chk("trigger count", 16'(n0 + k), 16'(n_st));
            wr(8'h27, 16'h0000);
        end
        // Level sensing: one start pulse per cycle the pin stays high
        wr(8'h43, 16'h0000);
        n0 = n_st;
        trg <= 1'b1;
        repeat (10) @(posedge clk);
        trg <= 1'b0;
        repeat (10) @(posedge clk);
        chk("level trigger", 16'(n0 + 10), 16'(n_st));
        rd(8'h03, 16'h1100);
        wr(8'h03, 16'h0200);
        rd(8'h03, 16'h1000);
    endtask
    task automatic t_timebase(input logic [15:0] d, input int e);
        int no;
        int ns;
        no = 0;
        ns = 0;
        wr(8'h38, d);
        repeat (4) @(posedge clk);
        repeat (20) begin
            @(posedge clk);
            #1 no += int'(oen);
            ns += int'(sen);
        end
        chk("out timebase", 16'(e), 16'(no));
        chk("src timebase", 16'(e), 16'(ns));
    endtask
    // Main sequence: reset for four cycles, then the scenarios
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_preload();
        t_overrun();
        t_multi();
        t_mute();
        t_pause_reset();
        t_cpu_trig();
        t_timebase(16'h0030, 10);
        t_timebase(16'h0000, 20);
        stop_test();
    end
endmodule
`default_nettype wire
